// ---- iic_top.sv ----
`timescale 1ns/10ps
`include "iic_cfg.svh"

module iic_top #(
   parameter int NUM_CH     = `IIC_NUM_CH,
   parameter int CYCLE_CLKS = `IIC_CYCLE_CLKS
) (
   input  wire logic                            ref_clk,
   input  wire logic                            resetn,
   input  wire logic                            ce,
   input  wire iic_pkg::iic_bus_s               bus,
   output logic [31:0]                          rdata,
   input  wire iic_pkg::iic_volt_t [NUM_CH-1:0] volts,
   output logic [NUM_CH-1:0]                    raw,
   output logic [NUM_CH-1:0]                    status,
   output logic                                 tick
);
   import iic_pkg::*;

   iic_lvl_t      [NUM_CH-1:0] pick_lvl;
   iic_lvl_t      [NUM_CH-1:0] drop_lvl;
   iic_time_t     [NUM_CH-1:0] pick_time;
   iic_time_t     [NUM_CH-1:0] drop_time;
   logic          [NUM_CH-1:0] sense;
   logic          [NUM_CH-1:0] ac;
   iic_chan_cfg_s [NUM_CH-1:0] cfg;
   logic          [31:0]       next_rdata;

   // Address decode for one field of one channel
   function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [7:0] fld);
      return a == 8'(8'(ch * `IIC_CH_STRIDE) + fld);
   endfunction

   // Evaluation cycle strobe
   iic_tick #(
      .CYCLE_CLKS (CYCLE_CLKS)
   ) u_tick (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .ce      (ce),
      .tick    (tick)
   );

   // Common control word: sense and alternating-supply bits
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         sense <= {NUM_CH{`IIC_SENSE_RST}};
         ac    <= {NUM_CH{`IIC_AC_RST}};
      end else if (ce && bus.wr && bus.addr == `IIC_OFS_CTRL) begin
         sense <= bus.wdata[`IIC_CTRL_SENSE_LSB +: NUM_CH];
         ac    <= bus.wdata[`IIC_CTRL_AC_LSB +: NUM_CH];
      end
   end

   // One block of settings and one conditioner per channel
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch

      // Pick-up and dropout levels in 0.1 V units
      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            pick_lvl[i] <= `IIC_PICK_LVL_RST;
            drop_lvl[i] <= `IIC_DROP_LVL_RST;
         end else if (ce && bus.wr) begin
            if (ch_hit(bus.addr, i, `IIC_OFS_PICK_LVL)) begin
               pick_lvl[i] <= bus.wdata[`IIC_LVL_W-1:0];
            end
            if (ch_hit(bus.addr, i, `IIC_OFS_DROP_LVL)) begin
               drop_lvl[i] <= bus.wdata[`IIC_LVL_W-1:0];
            end
         end
      end

      // Pick-up and dropout times in ms
      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            pick_time[i] <= `IIC_TIME_RST;
            drop_time[i] <= `IIC_TIME_RST;
         end else if (ce && bus.wr) begin
            if (ch_hit(bus.addr, i, `IIC_OFS_PICK_TIME)) begin
               pick_time[i] <= bus.wdata[`IIC_TIME_W-1:0];
            end
            if (ch_hit(bus.addr, i, `IIC_OFS_DROP_TIME)) begin
               drop_time[i] <= bus.wdata[`IIC_TIME_W-1:0];
            end
         end
      end

      // Gather the settings for the conditioner
      assign cfg[i] = '{
         pick_lvl:  pick_lvl[i],
         drop_lvl:  drop_lvl[i],
         pick_time: pick_time[i],
         drop_time: drop_time[i],
         sense:     sense[i],
         ac:        ac[i]
      };

      iic_channel u_chan (
         .ref_clk (ref_clk),
         .resetn  (resetn),
         .ce      (ce),
         .tick    (tick),
         .volts   (volts[i]),
         .cfg     (cfg[i]),
         .raw     (raw[i]),
         .status  (status[i])
      );

      // Normally open: above pick-up the raw state goes active
      property p_no_high;
         @(posedge ref_clk) disable iff (!resetn)
         tick && !sense[i] && (volts[i] > `IIC_VOLT_W'(pick_lvl[i])) |=> raw[i];
      endproperty
      a_no_high: assert property (p_no_high)
         else $error("raw not active above pick-up level in open sense");

      // Normally closed: above pick-up the raw state goes inactive
      property p_nc_high;
         @(posedge ref_clk) disable iff (!resetn)
         tick && sense[i] && (volts[i] > `IIC_VOLT_W'(pick_lvl[i])) |=> !raw[i];
      endproperty
      a_nc_high: assert property (p_nc_high)
         else $error("raw not inactive above pick-up level in closed sense");

      // Normally open below dropout gives inactive when the alternating supply is off
      property p_no_low;
         @(posedge ref_clk) disable iff (!resetn)
         tick && !sense[i] && !ac[i] && (volts[i] < `IIC_VOLT_W'(drop_lvl[i]))
            && (volts[i] <= `IIC_VOLT_W'(pick_lvl[i])) |=> !raw[i];
      endproperty
      a_no_low: assert property (p_no_low)
         else $error("raw still active below dropout level");

      // Between the two levels the raw state is held when the alternating supply is off
      property p_hold;
         @(posedge ref_clk) disable iff (!resetn)
         tick && !ac[i] && (volts[i] >= `IIC_VOLT_W'(drop_lvl[i]))
            && (volts[i] <= `IIC_VOLT_W'(pick_lvl[i])) |=> $stable(raw[i]);
      endproperty
      a_hold: assert property (p_hold)
         else $error("raw changed inside the hysteresis band");

      // Alternating supply releases below a tenth of the pick-up level
      property p_ac_release;
         @(posedge ref_clk) disable iff (!resetn)
         tick && ac[i] && (volts[i] < `IIC_VOLT_W'(pick_lvl[i] / `IIC_AC_DIV))
            |=> (raw[i] == sense[i]);
      endproperty
      a_ac_release: assert property (p_ac_release)
         else $error("release level not derived from pick-up level");

      // Zero pick-up time lets the status follow at once
      property p_pick_zero;
         @(posedge ref_clk) disable iff (!resetn)
         $rose(raw[i]) && ($past(pick_time[i]) == '0) |-> status[i];
      endproperty
      a_pick_zero: assert property (p_pick_zero)
         else $error("status lagged with zero pick-up time");

      // Zero dropout time lets the status fall at once when the alternating supply is off
      property p_drop_zero;
         @(posedge ref_clk) disable iff (!resetn)
         $fell(raw[i]) && ($past(drop_time[i]) == '0) && !$past(ac[i]) |-> !status[i];
      endproperty
      a_drop_zero: assert property (p_drop_zero)
         else $error("status lagged with zero dropout time");

      // A non-zero pick-up time keeps the status low at the first boundary
      property p_pick_wait;
         @(posedge ref_clk) disable iff (!resetn)
         $rose(raw[i]) && !$past(status[i]) && ($past(pick_time[i]) != '0) |-> !status[i];
      endproperty
      a_pick_wait: assert property (p_pick_wait)
         else $error("status rose before the pick-up time");

      // A non-zero dropout time keeps the status high at the first boundary
      property p_drop_wait;
         @(posedge ref_clk) disable iff (!resetn)
         $fell(raw[i]) && $past(status[i]) && ($past(drop_time[i]) != '0) |-> status[i];
      endproperty
      a_drop_wait: assert property (p_drop_wait)
         else $error("status fell before the dropout time");

      // Alternating supply always delays the fall past the current cycle
      property p_ac_extra;
         @(posedge ref_clk) disable iff (!resetn)
         $fell(raw[i]) && $past(ac[i]) && $past(status[i]) |-> status[i] ##1 status[i];
      endproperty
      a_ac_extra: assert property (p_ac_extra)
         else $error("status fell without the extra dropout delay");

      // A status change only ever follows the raw state
      property p_follow;
         @(posedge ref_clk) disable iff (!resetn)
         $changed(status[i]) |-> (status[i] == raw[i]);
      endproperty
      a_follow: assert property (p_follow)
         else $error("status moved against the raw state");

      // Defaults after reset
      property p_defaults;
         @(posedge ref_clk) disable iff (!resetn)
         $rose(resetn) |-> (pick_lvl[i] == `IIC_PICK_LVL_RST)
            && (drop_lvl[i] == `IIC_DROP_LVL_RST) && !sense[i] && !ac[i]
            && (pick_time[i] == `IIC_TIME_RST) && (drop_time[i] == `IIC_TIME_RST);
      endproperty
      a_defaults: assert property (p_defaults)
         else $error("settings not at their defaults after reset");
   end

   // Read mux over all registers, unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (bus.addr == `IIC_OFS_CTRL) begin
         next_rdata[`IIC_CTRL_SENSE_LSB +: NUM_CH] = sense;
         next_rdata[`IIC_CTRL_AC_LSB +: NUM_CH]    = ac;
      end
      if (bus.addr == `IIC_OFS_STAT) begin
         next_rdata[`IIC_STAT_QUAL_LSB +: NUM_CH] = status;
         next_rdata[`IIC_STAT_RAW_LSB +: NUM_CH]  = raw;
      end
      for (int c = 0; c < NUM_CH; c++) begin
         if (ch_hit(bus.addr, c, `IIC_OFS_PICK_LVL)) begin
            next_rdata[`IIC_LVL_W-1:0] = pick_lvl[c];
         end
         if (ch_hit(bus.addr, c, `IIC_OFS_DROP_LVL)) begin
            next_rdata[`IIC_LVL_W-1:0] = drop_lvl[c];
         end
         if (ch_hit(bus.addr, c, `IIC_OFS_PICK_TIME)) begin
            next_rdata[`IIC_TIME_W-1:0] = pick_time[c];
         end
         if (ch_hit(bus.addr, c, `IIC_OFS_DROP_TIME)) begin
            next_rdata[`IIC_TIME_W-1:0] = drop_time[c];
         end
      end
   end

   // Read data stands for one enabled cycle after the strobe, then zero; it holds while the enable is low
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         rdata <= bus.rd ? next_rdata : 32'h0000_0000;
      end
   end

   // Helper: enabled cycles since the last boundary
   int gap;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         gap <= 0;
      end else if (ce) begin
         gap <= tick ? 0 : gap + 1;
      end
   end

   // Boundaries come exactly one evaluation cycle apart
   property p_period;
      @(posedge ref_clk) disable iff (!resetn)
      tick |-> (gap == CYCLE_CLKS - 1);
   endproperty
   a_period: assert property (p_period)
      else $error("evaluation cycle length wrong");

   // Outputs move only right after a boundary
   property p_on_tick;
      @(posedge ref_clk) disable iff (!resetn)
      ($changed(status) || $changed(raw)) |-> $past(tick);
   endproperty
   a_on_tick: assert property (p_on_tick)
      else $error("channel state changed between boundaries");

   // Status word reads back the channel state one cycle later
   property p_stat_read;
      @(posedge ref_clk) disable iff (!resetn)
      ce && bus.rd && (bus.addr == `IIC_OFS_STAT) && !tick
         |=> (rdata[`IIC_STAT_QUAL_LSB +: NUM_CH] == status)
          && (rdata[`IIC_STAT_RAW_LSB +: NUM_CH] == raw);
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status word does not show channel state");

   // Control word reads back the sense and alternating-supply bits
   property p_ctrl_read;
      @(posedge ref_clk) disable iff (!resetn)
      ce && bus.rd && (bus.addr == `IIC_OFS_CTRL)
         |=> (rdata[`IIC_CTRL_SENSE_LSB +: NUM_CH] == sense)
          && (rdata[`IIC_CTRL_AC_LSB +: NUM_CH] == ac);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control word does not show sense and option bits");

   // A low enable freezes the channel state and the read data
   property p_freeze;
      @(posedge ref_clk) disable iff (!resetn)
      !ce |=> $stable(raw) && $stable(status) && $stable(rdata);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while the enable was low");

endmodule // iic_top

// ---- iic_cfg.svh ----
`ifndef IIC_CFG_SVH
`define IIC_CFG_SVH

// Channel count and field widths
`define IIC_NUM_CH        8
`define IIC_VOLT_W        13
`define IIC_LVL_W         12
`define IIC_TIME_W        21
`define IIC_ELAPSED_W     22

// Clock period and evaluation cycle
`define IIC_CLK_PERIOD_NS 5
`define IIC_CYCLE_MS      5
`define IIC_CYCLE_CLKS    (`IIC_CYCLE_MS * 1000000 / `IIC_CLK_PERIOD_NS)

// Alternating-supply extras: extra drop time and release divisor (10 %)
`define IIC_AC_EXTRA_MS   30
`define IIC_AC_DIV        10

// Reset values, levels in 0.1 V units, times in ms
`define IIC_PICK_LVL_RST  12'h370
`define IIC_DROP_LVL_RST  12'h258
`define IIC_TIME_RST      21'h0_0000
`define IIC_SENSE_RST     1'b0
`define IIC_AC_RST        1'b0

// Register map: per-channel block plus two common words
`define IIC_CH_STRIDE     8'h10
`define IIC_OFS_PICK_LVL  8'h00
`define IIC_OFS_DROP_LVL  8'h04
`define IIC_OFS_PICK_TIME 8'h08
`define IIC_OFS_DROP_TIME 8'h0C
`define IIC_OFS_CTRL      8'h80
`define IIC_OFS_STAT      8'h84

// Bit positions inside the common words
`define IIC_CTRL_SENSE_LSB 0
`define IIC_CTRL_AC_LSB    8
`define IIC_STAT_QUAL_LSB  0
`define IIC_STAT_RAW_LSB   8

`endif

// ---- iic_pkg.sv ----
`include "iic_cfg.svh"

package iic_pkg;

   typedef logic [`IIC_VOLT_W-1:0]    iic_volt_t;
   typedef logic [`IIC_LVL_W-1:0]     iic_lvl_t;
   typedef logic [`IIC_TIME_W-1:0]    iic_time_t;
   typedef logic [`IIC_ELAPSED_W-1:0] iic_elapsed_t;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } iic_bus_s;

   // Settings of one input channel
   typedef struct packed {
      iic_lvl_t  pick_lvl;
      iic_lvl_t  drop_lvl;
      iic_time_t pick_time;
      iic_time_t drop_time;
      logic      sense;
      logic      ac;
   } iic_chan_cfg_s;

endpackage

// ---- iic_tick.sv ----
`timescale 1ns/10ps
`include "iic_cfg.svh"

module iic_tick #(
   parameter int CYCLE_CLKS = `IIC_CYCLE_CLKS
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic ce,
   output logic      tick
);
   import iic_pkg::*;

   localparam int CW = $clog2(CYCLE_CLKS);

   logic [CW-1:0] cnt;

   // Free-running divider, frozen while the enable is low
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt <= '0;
      end else if (ce) begin
         cnt <= tick ? '0 : CW'(cnt + 1'b1);
      end
   end

   // One-cycle strobe at each cycle boundary
   assign tick = ce && (cnt == CW'(CYCLE_CLKS - 1));

endmodule // iic_tick

// ---- iic_channel.sv ----
`timescale 1ns/10ps
`include "iic_cfg.svh"

module iic_channel (
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  tick,
   input  wire iic_pkg::iic_volt_t    volts,
   input  wire iic_pkg::iic_chan_cfg_s cfg,
   output logic                       raw,
   output logic                       status
);
   import iic_pkg::*;

   logic         energized;
   logic         next_energized;
   logic         next_raw;
   iic_volt_t    release_lvl;
   iic_elapsed_t need;
   iic_elapsed_t elapsed;

   // Threshold comparison with hysteresis and sense selection
   always_comb begin
      release_lvl = cfg.ac ? `IIC_VOLT_W'(cfg.pick_lvl / `IIC_AC_DIV)
                           : `IIC_VOLT_W'(cfg.drop_lvl);
      next_energized = energized;
      if (volts > `IIC_VOLT_W'(cfg.pick_lvl)) begin
         next_energized = 1'b1;
      end else if (volts < release_lvl) begin
         next_energized = 1'b0;
      end
      next_raw = next_energized ^ cfg.sense;
      if (next_raw) begin
         need = `IIC_ELAPSED_W'(cfg.pick_time);
      end else begin
         need = `IIC_ELAPSED_W'(cfg.drop_time)
              + (cfg.ac ? `IIC_ELAPSED_W'(`IIC_AC_EXTRA_MS) : '0);
      end
   end

   // Raw state, moved only at cycle boundaries
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         energized <= 1'b0;
         raw       <= 1'b0;
      end else if (ce && tick) begin
         energized <= next_energized;
         raw       <= next_raw;
      end
   end

   // Qualified status with pick-up and drop-off timing
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         status  <= 1'b0;
         elapsed <= '0;
      end else if (ce && tick) begin
         if (next_raw == status) begin
            elapsed <= '0;
         end else if (elapsed >= need) begin
            status  <= next_raw;
            elapsed <= '0;
         end else begin
            elapsed <= `IIC_ELAPSED_W'(elapsed + `IIC_CYCLE_MS);
         end
      end
   end

endmodule // iic_channel

// ---- iic_front_model.sv ----
`timescale 1ns/10ps

module iic_front_model #(
   parameter int NUM_CH = 8,
   parameter int LAG    = 7
) (
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   input  wire logic                       set,
   input  wire logic                       slow,
   input  wire logic [2:0]                 ch,
   input  wire iic_pkg::iic_volt_t         level,
   output iic_pkg::iic_volt_t [NUM_CH-1:0] volts
);
   import iic_pkg::*;

   iic_volt_t pend     [NUM_CH];
   int        wait_cnt [NUM_CH];

   // Each channel settles on a new level one cycle later, or after a slow conversion lag
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (!resetn) begin
            volts[i]    <= '0;
            wait_cnt[i] <= 0;
         end else if (set && ch == 3'(i)) begin
            pend[i]     <= level;
            wait_cnt[i] <= slow ? LAG : 1;
         end else if (wait_cnt[i] == 1) begin
            volts[i]    <= pend[i];
            wait_cnt[i] <= 0;
         end else if (wait_cnt[i] > 1) begin
            wait_cnt[i] <= wait_cnt[i] - 1;
         end
      end
   end
endmodule // iic_front_model

// ---- isolated_input_conditioner_test.sv ----
`timescale 1ns/10ps

module isolated_input_conditioner_test;
   import iic_pkg::*;

   localparam int NUM_CH = 8;
   localparam int CYC    = 20;

   logic                   ref_clk, resetn, ce, set, slow, tick;
   logic [2:0]             vch;
   iic_volt_t              vlev;
   iic_bus_s               bus;
   logic [31:0]            rdata;
   iic_volt_t [NUM_CH-1:0] volts;
   logic [NUM_CH-1:0]      raw, status, exp_raw, exp_stat;
   iic_chan_cfg_s          cfg     [NUM_CH];
   int                     elapsed [NUM_CH];
   int                     cnt, cyc_total, err_total, n_checks;

   iic_top #(.NUM_CH(NUM_CH), .CYCLE_CLKS(CYC)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .ce(ce), .bus(bus), .rdata(rdata), .volts(volts), .raw(raw), .status(status),
      .tick(tick));
   iic_front_model #(.NUM_CH(NUM_CH)) front_u (.ref_clk(ref_clk), .resetn(resetn),
      .set(set), .slow(slow), .ch(vch), .level(vlev), .volts(volts));

   always #2.5 ref_clk = ~ref_clk;

   // Raw state from levels and sense; the band between the levels holds the old state
   function automatic logic eval_raw(iic_chan_cfg_s c, iic_volt_t v, logic prev);
      int rel;
      rel = c.ac ? c.pick_lvl / 10 : c.drop_lvl;
      if (v > c.pick_lvl) return ~c.sense;
      if (v < rel) return c.sense;
      return prev;
   endfunction

   // Reference channels, stepped on a private copy of the evaluation counter
   always @(posedge ref_clk) begin : ref_model
      logic r;
      int   need;
      if (!resetn) begin
         cnt      <= 0;
         exp_raw  <= '0;
         exp_stat <= '0;
         foreach (elapsed[i]) elapsed[i] <= 0;
      end else if (ce) begin
         cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
         if (cnt == CYC - 1) begin
            for (int i = 0; i < NUM_CH; i++) begin
               r = eval_raw(cfg[i], volts[i], exp_raw[i]);
               need = r ? cfg[i].pick_time : cfg[i].drop_time + (cfg[i].ac ? 30 : 0);
               exp_raw[i] <= r;
               if (r == exp_stat[i]) begin
                  elapsed[i] <= 0;
               end else if (elapsed[i] >= need) begin
                  exp_stat[i] <= r;
                  elapsed[i]  <= 0;
               end else begin
                  elapsed[i] <= elapsed[i] + 5;
               end
            end
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Outputs compared every cycle once the edge updates have landed
   always @(negedge ref_clk) begin
      if (resetn) begin
         check(32'(raw), 32'(exp_raw));
         check(32'(status), 32'(exp_stat));
         check(32'(tick), 32'(ce && cnt == CYC - 1));
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
      // Mirror follows the write at the edge that takes it
      if (a == 8'h80) begin
         foreach (cfg[i]) begin
            cfg[i].sense <= d[i];
            cfg[i].ac    <= d[8+i];
         end
      end else if (a < 8'h80) begin
         case (a[3:0])
            4'h0: cfg[a[6:4]].pick_lvl <= d[11:0];
            4'h4: cfg[a[6:4]].drop_lvl <= d[11:0];
            4'h8: cfg[a[6:4]].pick_time <= d[20:0];
            4'hC: cfg[a[6:4]].drop_time <= d[20:0];
            default: ;
         endcase
      end
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] e;
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge ref_clk);
      e = (a == 8'h84) ? {16'h0000, exp_raw, exp_stat} : exp;
      bus.rd <= 1'b0;
      @(negedge ref_clk);
      check(rdata, e);
      // The return to zero lands at the next edge, so look at it mid-cycle
      @(negedge ref_clk);
      check(rdata, 32'h0000_0000);
      @(posedge ref_clk);
   endtask

   task automatic setv(input int c, input int v);
      set  <= 1'b1;
      vch  <= 3'(c);
      vlev <= 13'(v);
      @(posedge ref_clk);
      set <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic ticks(input int n);
      repeat (n * CYC) @(posedge ref_clk);
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge ref_clk) begin
      cyc_total <= cyc_total + 1;
      if (cyc_total == 40000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      ce = 1'b1;
      set = 1'b0;
      slow = 1'b0;
      vch = '0;
      vlev = '0;
      bus = '0;
      cyc_total = 0;
      err_total = 0;
      n_checks = 0;
      foreach (cfg[i]) cfg[i] = '{12'h370, 12'h258, 21'h0_0000, 21'h0_0000, 1'b0, 1'b0};
      void'($urandom(83));
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rd(8'h00, 32'h0000_0370);
      rd(8'h74, 32'h0000_0258);
      rd(8'h38, 32'h0000_0000);
      rd(8'h7C, 32'h0000_0000);
      rd(8'h80, 32'h0000_0000);
      rd(8'h88, 32'h0000_0000);
      rd(8'h84, 32'h0000_0000);
      $display("Test defaults done");
      // Mixed sense per channel, levels on both sides, then into the band
      wr(8'h80, 32'h0000_00A5);
      for (int i = 0; i < NUM_CH; i++) setv(i, i[0] ? 500 : 1000);
      ticks(2);
      rd(8'h84, 32'h0);
      setv(0, 700);
      setv(1, 700);
      ticks(2);
      $display("Test sense and band done");
      // Pick-up 10 ms, dropout 7 ms rounding up; a revert cancels
      wr(8'h18, 32'h0000_000A);
      wr(8'h1C, 32'h0000_0007);
      setv(1, 1000);
      ticks(1);
      setv(1, 100);
      ticks(3);
      setv(1, 1000);
      ticks(4);
      setv(1, 100);
      ticks(4);
      $display("Test delays done");
      // Alternating supply on open-sense channel 4: tenth-level release, 30 ms extra drop
      wr(8'h80, 32'h0000_10A5);
      setv(4, 1000);
      ticks(2);
      setv(4, 300);
      ticks(3);
      setv(4, 50);
      ticks(9);
      $display("Test alternating supply done");
      // Clock enable held low freezes the conditioner; the front end still settles
      ce <= 1'b0;
      setv(3, 1000);
      repeat (37) @(posedge ref_clk);
      ce <= 1'b1;
      ticks(2);
      $display("Test clock enable done");
      // Random levels, settings and front-end lag
      for (int n = 0; n < 60; n++) begin
         slow <= 1'($urandom_range(1));
         setv($urandom_range(7), $urandom_range(1200));
         case ($urandom_range(4))
            0: wr({1'b0, 3'($urandom_range(7)), 4'h0}, 32'($urandom_range(2000, 160)));
            1: wr({1'b0, 3'($urandom_range(7)), 4'h4}, 32'($urandom_range(1999, 100)));
            2: wr({1'b0, 3'($urandom_range(7)), 4'h8}, 32'($urandom_range(40)));
            3: wr({1'b0, 3'($urandom_range(7)), 4'hC}, 32'($urandom_range(40)));
            default: wr(8'h80, {16'h0000, 8'($urandom_range(255)), 8'hA5});
         endcase
         repeat ($urandom_range(30)) @(posedge ref_clk);
         rd(8'h84, 32'h0);
         rd(8'h50, {20'h0_0000, cfg[5].pick_lvl});
      end
      $display("Test random done");
      end_of_test();
   end
endmodule // isolated_input_conditioner_test
